// File: bench/hesc_link_properties.sv
`timescale 1ns/100ps
module hesc_link_properties (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic tok_valid,
    input hesc_pkg::hesc_pid_t tok_pid,
    input wire logic [3:0] tok_ep,
    input wire logic set_config,
    input hesc_pkg::hesc_hs_t resp_hs,
    input wire logic resp_valid,
    input wire logic [7:0] in_data,
    input wire logic in_valid,
    input wire logic in_last
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic cfg_reg;
    logic [7:0] cnt_reg;
    logic poll1;
    assign poll1 = tok_valid && tok_pid == hesc_pkg::HESC_PID_IN && tok_ep == hesc_pkg::EP_INTR;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) cfg_reg <= 1'b0;
        else if (set_config) cfg_reg <= 1'b1;
    end
    // Byte count restarts on each token, so a continued packet is judged alone
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) cnt_reg <= 8'h00;
        else if (tok_valid) cnt_reg <= 8'h00;
        else if (in_valid && cnt_reg != 8'hff) cnt_reg <= cnt_reg + 8'h01;
    end
    property p_int_answer; poll1 |=> resp_valid; endproperty
    a_int_answer: assert property (p_int_answer) else $error("no answer to poll");
    property p_unconfig_stall; poll1 && !cfg_reg |=> resp_valid && resp_hs == hesc_pkg::HESC_HS_STALL; endproperty
    a_unconfig_stall: assert property (p_unconfig_stall) else $error("poll served early");
    property p_cfg_served; poll1 && cfg_reg |=> resp_valid && resp_hs != hesc_pkg::HESC_HS_STALL; endproperty
    a_cfg_served: assert property (p_cfg_served) else $error("poll refused after config");
    property p_bad_ep; tok_valid && tok_ep > hesc_pkg::EP_INTR |=> resp_valid && resp_hs == hesc_pkg::HESC_HS_STALL;
    endproperty
    a_bad_ep: assert property (p_bad_ep) else $error("unknown endpoint served");
    property p_one_byte; poll1 && cfg_reg ##1 resp_valid && resp_hs == hesc_pkg::HESC_HS_DATA
        |-> in_valid && in_last ##1 !in_valid; endproperty
    a_one_byte: assert property (p_one_byte) else $error("status not one byte");
    property p_nak_empty; resp_valid && resp_hs == hesc_pkg::HESC_HS_NAK |-> !in_valid; endproperty
    a_nak_empty: assert property (p_nak_empty) else $error("data with nak");
    property p_map_nonzero; poll1 ##1 resp_valid && resp_hs == hesc_pkg::HESC_HS_DATA |-> in_data != 8'h00;
    endproperty
    a_map_nonzero: assert property (p_map_nonzero) else $error("empty status sent");
    property p_pkt_max; in_valid |-> cnt_reg < 8'h40; endproperty
    a_pkt_max: assert property (p_pkt_max) else $error("packet over 64 bytes");
    property p_last_valid; in_last |-> in_valid; endproperty
    a_last_valid: assert property (p_last_valid) else $error("stray last flag");
endmodule

// File: bench/hub_endpoint_status_change_tb_top.sv
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
    $display("unexpected at %0t: got %0h want %0h", $time, a, b); end end
module hub_endpoint_status_change_tb_top;
    logic clock, rst_b, two_lang, hub_chg_a, hub_chg_b, rd_a, rd_b, cfg_a, cfg_b;
    logic cmd_config, cmd_fetch, cfg_seen, map_valid, rx_valid, watch_ff;
    logic [6:0] port_chg_a, port_chg_b;
    logic [7:0] addr_a, addr_b, data_a, data_b, map_a, map_b, last_map, rx_byte, cmd_index, d;
    logic [2:0] cmd_desc;
    logic l;
    hesc_pkg::hesc_hs_t hs;
    int err_total, total_checks, maps, bad_rd;
    logic [7:0] rxq[$];
    hesc_link_if link_a();
    hesc_link_if link_b();
    hesc_hub_end i_hesc_hub_end (.clock(clock), .rst_b(rst_b), .link(link_a), .two_lang(two_lang),
        .hub_change(hub_chg_a), .port_change(port_chg_a), .img_addr(addr_a), .img_rd(rd_a), .img_data(data_a),
        .configured(cfg_a), .change_map(map_a));
    hesc_host_end #(.POLL_CYCLES(50)) i_hesc_host_end (.clock(clock), .rst_b(rst_b), .link(link_a),
        .cmd_config(cmd_config), .cmd_fetch(cmd_fetch), .cmd_desc(cmd_desc), .cmd_index(cmd_index),
        .configured_seen(cfg_seen), .last_map(last_map), .map_valid(map_valid), .rx_byte(rx_byte),
        .rx_valid(rx_valid));
    // Second hub faces the bench directly so refusals can be forced
    hesc_hub_end i_hesc_hub_end_b (.clock(clock), .rst_b(rst_b), .link(link_b), .two_lang(1'b0),
        .hub_change(hub_chg_b), .port_change(port_chg_b), .img_addr(addr_b), .img_rd(rd_b), .img_data(data_b),
        .configured(cfg_b), .change_map(map_b));
    hesc_link_properties i_hesc_link_properties (.clock(clock), .rst_b(rst_b), .tok_valid(link_a.tok_valid),
        .tok_pid(link_a.tok_pid), .tok_ep(link_a.tok_ep), .set_config(link_a.set_config),
        .resp_hs(link_a.resp_hs), .resp_valid(link_a.resp_valid), .in_data(link_a.in_data),
        .in_valid(link_a.in_valid), .in_last(link_a.in_last));
    function automatic logic [7:0] img(input logic [7:0] a);
        case (a)
            8'h0e, 8'h10: img = hesc_pkg::EMPTY_STR_LEN;
            8'h0f: img = hesc_pkg::STR_TYPE;
            8'h11: img = 8'h7e;
            8'hff: img = 8'h20;
            default: img = a;
        endcase
    endfunction
    // Image answers in the cycle of its address, as the hub's fetch step expects
    assign data_a = img(addr_a);
    assign data_b = img(addr_b);
    always_ff @(posedge clock) begin
        if (rx_valid) rxq.push_back(rx_byte);
        if (map_valid) maps++;
        if (watch_ff && rd_a && addr_a != 8'hff) bad_rd++;
    end
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic poll(input logic [3:0] ep);
        link_b.tok_valid <= 1'b1;
        link_b.tok_ep <= ep;
        @(posedge clock);
        link_b.tok_valid <= 1'b0;
        #1;
        `CHK(link_b.resp_valid, 1'b1)
        hs = link_b.resp_hs;
        d = link_b.in_data;
        l = link_b.in_valid & link_b.in_last;
        @(posedge clock);
    endtask
    task automatic ack();
        link_b.ack <= 1'b1;
        @(posedge clock);
        link_b.ack <= 1'b0;
        @(posedge clock);
    endtask
    task automatic fetch(input hesc_pkg::hesc_desc_t desc, input logic [7:0] idx);
        rxq.delete();
        cmd_desc <= 3'(desc);
        cmd_index <= idx;
        cmd_fetch <= 1'b1;
        @(posedge clock);
        cmd_fetch <= 1'b0;
        repeat (300) @(posedge clock);
    endtask
    initial begin
        repeat (6000) @(posedge clock);
        err_total++;
        stop_test();
    end
    initial begin
        {rst_b, two_lang, hub_chg_a, hub_chg_b, cmd_config, cmd_fetch, watch_ff} = '0;
        {port_chg_a, port_chg_b, cmd_index, cmd_desc} = '0;
        {link_b.tok_valid, link_b.out_data, link_b.out_valid, link_b.out_last} = '0;
        {link_b.req_desc, link_b.req_index, link_b.set_config, link_b.ack, link_b.tok_ep} = '0;
        link_b.tok_pid = hesc_pkg::HESC_PID_IN;
        err_total = 0; total_checks = 0; maps = 0; bad_rd = 0;
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        poll(hesc_pkg::EP_INTR);
        `CHK(hs, hesc_pkg::HESC_HS_STALL)
        for (int e = 2; e < 16; e++) begin
            poll(4'(e));
            `CHK(hs, hesc_pkg::HESC_HS_STALL)
        end
        port_chg_a <= 7'h01;
        @(posedge clock);
        port_chg_a <= 7'h00;
        repeat (150) @(posedge clock);
        `CHK(maps, 0)
        `CHK(cfg_b, 1'b0)
        `CHK(cfg_a, 1'b0)
        $display("test refusals done");
        link_b.set_config <= 1'b1;
        cmd_config <= 1'b1;
        @(posedge clock);
        link_b.set_config <= 1'b0;
        cmd_config <= 1'b0;
        repeat (200) @(posedge clock);
        `CHK(cfg_b, 1'b1)
        `CHK(cfg_a, 1'b1)
        `CHK(cfg_seen, 1'b1)
        `CHK(maps > 0, 1'b1)
        `CHK(last_map, 8'h02)
        `CHK(map_a, 8'h00)
        poll(hesc_pkg::EP_INTR);
        `CHK(hs, hesc_pkg::HESC_HS_NAK)
        for (int k = 0; k < 8; k++) begin
            if (k == 0) hub_chg_b <= 1'b1;
            else port_chg_b <= 7'(1 << (k - 1));
            @(posedge clock);
            hub_chg_b <= 1'b0;
            port_chg_b <= 7'h00;
            @(posedge clock);
            poll(hesc_pkg::EP_INTR);
            `CHK(hs, hesc_pkg::HESC_HS_DATA)
            `CHK(d, 8'(1 << k))
            `CHK(l, 1'b1)
            // A bare token in place of the ack sends the report back to idle unanswered
            link_b.tok_valid <= 1'b1;
            @(posedge clock);
            link_b.tok_valid <= 1'b0;
            @(posedge clock);
            poll(hesc_pkg::EP_INTR);
            `CHK(hs, hesc_pkg::HESC_HS_DATA)
            `CHK(d, 8'(1 << k))
            ack();
            `CHK(map_b, 8'h00)
            poll(hesc_pkg::EP_INTR);
            `CHK(hs, hesc_pkg::HESC_HS_NAK)
        end
        $display("test status bitmap done");
        fetch(hesc_pkg::HESC_DESC_STRING, 8'h00);
        `CHK(rxq.size(), 2)
        `CHK(rxq[1], hesc_pkg::STR_TYPE)
        two_lang <= 1'b1;
        fetch(hesc_pkg::HESC_DESC_STRING, 8'h00);
        `CHK(rxq[0], hesc_pkg::EMPTY_STR_LEN)
        `CHK(rxq[1], 8'h7e)
        watch_ff <= 1'b1;
        fetch(hesc_pkg::HESC_DESC_STRING, 8'hef);
        `CHK(bad_rd, 0)
        `CHK(rxq.size(), 1)
        `CHK(rxq[0], 8'h20)
        watch_ff <= 1'b0;
        fetch(hesc_pkg::HESC_DESC_DEVICE, 8'h00);
        `CHK(rxq.size(), 18)
        `CHK(rxq[0], 8'h12)
        $display("test descriptors done");
        stop_test();
    end
endmodule

// File: rtl/hesc_host_end.sv
`timescale 1ns/100ps
// Host side: polls endpoint 1 and fetches descriptors on command
module hesc_host_end #(
    parameter int POLL_CYCLES = hesc_pkg::POLL_CYCLES
) (
    input wire logic clock,
    input wire logic rst_b,
    hesc_link_if.host link,
    input wire logic cmd_config,
    input wire logic cmd_fetch,
    input wire logic [2:0] cmd_desc,
    input wire logic [7:0] cmd_index,
    output logic configured_seen,
    output logic [7:0] last_map,
    output logic map_valid,
    output logic [7:0] rx_byte,
    output logic rx_valid
);
    logic [31:0] poll_cnt_reg;
    logic fetch_pend_reg;
    logic [2:0] fetch_desc_reg;
    logic [7:0] fetch_index_reg;
    logic setup_sent_reg;
    logic ctrl_busy_reg;
    logic intr_busy_reg;
    logic poll_due;
    logic link_idle;

    assign poll_due = configured_seen && poll_cnt_reg >= POLL_CYCLES - 1;
    // One transaction at a time: the hub drops tokens during a burst or before an ack
    assign link_idle = !ctrl_busy_reg && !intr_busy_reg;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            poll_cnt_reg <= 32'h0;
            fetch_pend_reg <= 1'b0;
            fetch_desc_reg <= 3'h0;
            fetch_index_reg <= 8'h00;
            setup_sent_reg <= 1'b0;
            ctrl_busy_reg <= 1'b0;
            intr_busy_reg <= 1'b0;
            configured_seen <= 1'b0;
            link.tok_valid <= 1'b0;
            link.tok_pid <= hesc_pkg::HESC_PID_NONE;
            link.tok_ep <= 4'h0;
            link.out_data <= 8'h00;
            link.out_valid <= 1'b0;
            link.out_last <= 1'b0;
            link.req_desc <= 3'h0;
            link.req_index <= 8'h00;
            link.set_config <= 1'b0;
            link.ack <= 1'b0;
            last_map <= 8'h00;
            map_valid <= 1'b0;
            rx_byte <= 8'h00;
            rx_valid <= 1'b0;
        end else begin
            link.tok_valid <= 1'b0;
            link.set_config <= 1'b0;
            link.ack <= 1'b0;
            map_valid <= 1'b0;
            rx_valid <= link.in_valid && link.tok_ep == hesc_pkg::EP_CTRL;
            rx_byte <= link.in_data;
            if (cmd_config) begin
                link.set_config <= 1'b1;
                configured_seen <= 1'b1;
            end
            if (configured_seen && !poll_due) begin
                poll_cnt_reg <= poll_cnt_reg + 32'h1;
            end
            if (setup_sent_reg) begin
                setup_sent_reg <= 1'b0;
                fetch_pend_reg <= 1'b0;
                ctrl_busy_reg <= 1'b1;
                link.tok_valid <= 1'b1;
                link.tok_pid <= hesc_pkg::HESC_PID_IN;
            end else if (link_idle && fetch_pend_reg) begin
                // SETUP first so the hub restarts the descriptor from its first byte
                setup_sent_reg <= 1'b1;
                link.tok_valid <= 1'b1;
                link.tok_pid <= hesc_pkg::HESC_PID_SETUP;
                link.tok_ep <= hesc_pkg::EP_CTRL;
                link.req_desc <= fetch_desc_reg;
                link.req_index <= fetch_index_reg;
            end else if (link_idle && poll_due) begin
                // A pending fetch delays the poll, so the period stretches slightly
                poll_cnt_reg <= 32'h0;
                intr_busy_reg <= 1'b1;
                link.tok_valid <= 1'b1;
                link.tok_pid <= hesc_pkg::HESC_PID_IN;
                link.tok_ep <= hesc_pkg::EP_INTR;
            end
            if (cmd_fetch) begin
                fetch_pend_reg <= 1'b1;
                fetch_desc_reg <= cmd_desc;
                fetch_index_reg <= cmd_index;
            end
            if (link.in_valid && link.in_last && link.tok_ep == hesc_pkg::EP_CTRL) begin
                ctrl_busy_reg <= 1'b0;
            end
            if (link.resp_valid && link.tok_ep == hesc_pkg::EP_INTR) begin
                intr_busy_reg <= 1'b0;
            end
            if (link.in_valid && link.tok_ep == hesc_pkg::EP_INTR) begin
                last_map <= link.in_data;
                map_valid <= 1'b1;
                link.ack <= 1'b1;
            end
        end
    end
endmodule

// File: rtl/hesc_hub_end.sv
`timescale 1ns/100ps
// Summary of operation
// - Unsupported string programmed with length 02H
// - Unsupported string keeps type byte slot
// - Manufacturer string at 0EH or 10H
// - String fetches never pass address FF
// - Only endpoints 0 and 1 exist
// - Control packets at most 64 bytes
// - Control endpoint returns the fixed device descriptor for every non-string request
// - Endpoint 1 interrupt IN, one byte
// - Endpoint 1 dead until Set Configuration
// - Host polls endpoint 1 every 255 ms
// - NAK when nothing pending, else bitmap
// - Bit 0 flags hub status change
// - Bits 1-7 flag port changes
module hesc_hub_end (
    input wire logic clock,
    input wire logic rst_b,
    hesc_link_if.hub link,
    input wire logic two_lang,
    input wire logic hub_change,
    input wire logic [6:0] port_change,
    output logic [7:0] img_addr,
    output logic img_rd,
    input wire logic [7:0] img_data,
    output logic configured,
    output logic [7:0] change_map
);
    typedef enum logic [2:0] {
        HESC_IDLE,
        HESC_FETCH,
        HESC_SEND,
        HESC_WAIT_ACK
    } hesc_state_t;

    hesc_state_t state_reg;
    logic [7:0] desc_len_reg;
    logic [7:0] sent_reg;
    logic [6:0] pkt_cnt_reg;
    logic [7:0] sent_map_reg;
    logic [7:0] rom [0:17];
    logic [7:0] desc_byte;
    logic [7:0] str_base;
    logic [7:0] next_addr;
    logic ctrl_in;

    // Fixed device descriptor; IDs are arbitrary neutral values
    always_comb begin
        rom[0] = 8'h12;
        rom[1] = 8'h01;
        rom[2] = 8'h00;
        rom[3] = 8'h02;
        rom[4] = 8'h09;
        rom[5] = 8'h00;
        rom[6] = 8'h01;
        rom[7] = 8'h40;
        rom[8] = hesc_pkg::VENDOR_ID_LO;
        rom[9] = hesc_pkg::VENDOR_ID_HI;
        rom[10] = 8'h00;
        rom[11] = 8'h01;
        rom[12] = 8'h00;
        rom[13] = 8'h01;
        rom[14] = 8'h01;
        rom[15] = 8'h02;
        rom[16] = 8'h03;
        rom[17] = 8'h01;
    end

    // Manufacturer string base depends on language count
    assign str_base = two_lang ? hesc_pkg::MFR_ADDR_TWO_LANG : hesc_pkg::MFR_ADDR_ONE_LANG;
    assign next_addr = img_addr + 8'h01;
    assign ctrl_in = link.tok_valid && link.tok_pid == hesc_pkg::HESC_PID_IN && link.tok_ep == hesc_pkg::EP_CTRL;

    always_comb begin
        desc_byte = 8'h00;
        case (hesc_pkg::hesc_desc_t'(link.req_desc))
            hesc_pkg::HESC_DESC_STRING: desc_byte = img_data;
            default: desc_byte = (sent_reg < 8'h12) ? rom[sent_reg[4:0]] : 8'h00;
        endcase
    end

    // Configuration state
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            configured <= 1'b0;
        end else if (link.set_config) begin
            configured <= 1'b1;
        end
    end

    // Change bitmap: set wins over clear, cleared only on host ack of reported bits
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            change_map <= 8'h00;
        end else begin
            change_map <= (change_map & ~((state_reg == HESC_WAIT_ACK && link.ack) ? sent_map_reg : 8'h00))
                | {port_change, hub_change};
        end
    end

    // Image walk holds at the top address rather than wrapping to the start
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            img_addr <= 8'h00;
            img_rd <= 1'b0;
        end else begin
            img_rd <= 1'b0;
            case (state_reg)
                HESC_IDLE: begin
                    if (ctrl_in && sent_reg == 8'h00) begin
                        img_addr <= str_base + link.req_index;
                    end
                    img_rd <= ctrl_in;
                end
                HESC_SEND: begin
                    if (img_addr != hesc_pkg::IMG_LAST_ADDR) begin
                        img_addr <= next_addr;
                        img_rd <= 1'b1;
                    end
                end
                default: img_rd <= 1'b0;
            endcase
        end
    end

    // Endpoint handling
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= HESC_IDLE;
            desc_len_reg <= 8'h00;
            sent_reg <= 8'h00;
            pkt_cnt_reg <= 7'h00;
            sent_map_reg <= 8'h00;
            link.resp_hs <= hesc_pkg::HESC_HS_NONE;
            link.resp_valid <= 1'b0;
            link.in_data <= 8'h00;
            link.in_valid <= 1'b0;
            link.in_last <= 1'b0;
        end else begin
            link.resp_valid <= 1'b0;
            link.in_valid <= 1'b0;
            link.in_last <= 1'b0;
            case (state_reg)
                HESC_IDLE: begin
                    if (link.tok_valid && link.tok_pid == hesc_pkg::HESC_PID_IN) begin
                        if (link.tok_ep == hesc_pkg::EP_INTR && configured) begin
                            if (change_map == 8'h00) begin
                                link.resp_hs <= hesc_pkg::HESC_HS_NAK;
                                link.resp_valid <= 1'b1;
                            end else begin
                                link.resp_hs <= hesc_pkg::HESC_HS_DATA;
                                link.resp_valid <= 1'b1;
                                link.in_data <= change_map;
                                link.in_valid <= 1'b1;
                                link.in_last <= 1'b1;
                                sent_map_reg <= change_map;
                                state_reg <= HESC_WAIT_ACK;
                            end
                        end else if (link.tok_ep == hesc_pkg::EP_CTRL) begin
                            pkt_cnt_reg <= 7'h00;
                            if (sent_reg == 8'h00) begin
                                desc_len_reg <= (link.req_desc == hesc_pkg::HESC_DESC_STRING) ? 8'h00 : rom[0];
                            end
                            state_reg <= HESC_FETCH;
                        end else begin
                            link.resp_hs <= hesc_pkg::HESC_HS_STALL;
                            link.resp_valid <= 1'b1;
                        end
                    end else if (link.tok_valid && link.tok_pid == hesc_pkg::HESC_PID_SETUP) begin
                        sent_reg <= 8'h00;
                    end else if (link.tok_valid && link.tok_pid == hesc_pkg::HESC_PID_OUT) begin
                        link.resp_hs <= (link.tok_ep == hesc_pkg::EP_CTRL) ? hesc_pkg::HESC_HS_DATA
                            : hesc_pkg::HESC_HS_STALL;
                        link.resp_valid <= 1'b1;
                    end
                end
                HESC_FETCH: begin
                    if (desc_len_reg == 8'h00 && link.req_desc == hesc_pkg::HESC_DESC_STRING) begin
                        desc_len_reg <= img_data;
                    end
                    state_reg <= HESC_SEND;
                end
                HESC_SEND: begin
                    link.resp_hs <= hesc_pkg::HESC_HS_DATA;
                    link.resp_valid <= (pkt_cnt_reg == 7'h00);
                    link.in_data <= desc_byte;
                    link.in_valid <= 1'b1;
                    sent_reg <= sent_reg + 8'h01;
                    pkt_cnt_reg <= pkt_cnt_reg + 7'h01;
                    // Stop at descriptor end, packet limit, or image boundary
                    if (sent_reg + 8'h01 >= desc_len_reg || pkt_cnt_reg + 7'h01 == hesc_pkg::EP0_MAX_PKT
                        || (link.req_desc == hesc_pkg::HESC_DESC_STRING
                        && img_addr == hesc_pkg::IMG_LAST_ADDR)) begin
                        link.in_last <= 1'b1;
                        if (sent_reg + 8'h01 >= desc_len_reg) begin
                            sent_reg <= 8'h00;
                        end
                        state_reg <= HESC_IDLE;
                    end
                end
                HESC_WAIT_ACK: begin
                    if (link.ack || (link.tok_valid && link.tok_pid == hesc_pkg::HESC_PID_IN)) begin
                        state_reg <= HESC_IDLE;
                    end
                end
                default: state_reg <= HESC_IDLE;
            endcase
        end
    end
endmodule

// File: rtl/hesc_link_if.sv
`timescale 1ns/100ps
interface hesc_link_if;
    logic tok_valid;
    hesc_pkg::hesc_pid_t tok_pid;
    logic [3:0] tok_ep;
    logic [7:0] out_data;
    logic out_valid;
    logic out_last;
    logic [2:0] req_desc;
    logic [7:0] req_index;
    logic set_config;
    logic ack;
    hesc_pkg::hesc_hs_t resp_hs;
    logic resp_valid;
    logic [7:0] in_data;
    logic in_valid;
    logic in_last;
    modport hub (
        input tok_valid, tok_pid, tok_ep, out_data, out_valid, out_last, req_desc, req_index, set_config, ack,
        output resp_hs, resp_valid, in_data, in_valid, in_last
    );
    modport host (
        output tok_valid, tok_pid, tok_ep, out_data, out_valid, out_last, req_desc, req_index, set_config, ack,
        input resp_hs, resp_valid, in_data, in_valid, in_last
    );
endinterface

// File: rtl/hesc_pkg.sv
package hesc_pkg;
    localparam logic [7:0] IMG_LAST_ADDR = 8'hff;
    localparam logic [7:0] MFR_ADDR_ONE_LANG = 8'h0e;
    localparam logic [7:0] MFR_ADDR_TWO_LANG = 8'h10;
    localparam logic [7:0] EMPTY_STR_LEN = 8'h02;
    localparam logic [7:0] STR_TYPE = 8'h03;
    localparam logic [6:0] EP0_MAX_PKT = 7'h40;
    localparam logic [3:0] EP_CTRL = 4'h0;
    localparam logic [3:0] EP_INTR = 4'h1;
    localparam logic [7:0] EP1_MAX_PKT = 8'h01;
    localparam int POLL_MS = 255;
    localparam int CLK_HZ = 50000000;
    localparam int POLL_CYCLES = POLL_MS * (CLK_HZ / 1000);
    localparam int PORT_COUNT = 7;
    localparam logic [7:0] VENDOR_ID_LO = 8'h5a;
    localparam logic [7:0] VENDOR_ID_HI = 8'ha5;
    typedef enum logic [1:0] {
        HESC_PID_NONE,
        HESC_PID_IN,
        HESC_PID_OUT,
        HESC_PID_SETUP
    } hesc_pid_t;
    typedef enum logic [1:0] {
        HESC_HS_NONE,
        HESC_HS_DATA,
        HESC_HS_NAK,
        HESC_HS_STALL
    } hesc_hs_t;
    typedef enum logic [2:0] {
        HESC_DESC_DEVICE,
        HESC_DESC_QUALIFIER,
        HESC_DESC_CONFIG,
        HESC_DESC_OTHER_SPEED,
        HESC_DESC_HUB,
        HESC_DESC_STRING
    } hesc_desc_t;
endpackage
